// >>> dv/modulation_duty_profile_regs_tb.sv
// Self-checking bench for the duty profile register bank.
// Assumes the bank answers reads one edge after the strobe and lookups two edges after.
`timescale 1ns/1ps
module modulation_duty_profile_regs_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] cfg_addr = 8'h00;
   logic cfg_wr = 1'b0;
   logic [31:0] cfg_wdata = 32'h0000_0000;
   logic cfg_rd = 1'b0;
   logic [31:0] cfg_rdata;
   logic cfg_rvalid;
   logic step_req = 1'b0;
   logic [2:0] step_sel = 3'h0;
   logic two_phase_sel = 1'b0;
   logic [duty_profile_pkg::DUTY_W-1:0] step_duty;
   logic step_duty_valid;
   logic [3:0] advance_deg;
   logic [31:0] two_word;
   int mismatches = 0;
   int samples_checked = 0;

   always #12.5 clk = ~clk;

   modulation_duty_profile_regs i_dut (
      .clk(clk), .rst_n(rst_n), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
      .cfg_wdata(cfg_wdata), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
      .cfg_rvalid(cfg_rvalid), .step_req(step_req), .step_sel(step_sel),
      .two_phase_sel(two_phase_sel), .step_duty(step_duty),
      .step_duty_valid(step_duty_valid), .advance_deg(advance_deg)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Duty in hundredths of a percent, written out independently of the package
   function automatic logic [13:0] duty_of(input logic [2:0] c);
      case (c)
         3'h0: duty_of = 14'h0000;
         3'h1: duty_of = 14'h1388;
         3'h2: duty_of = 14'h1d4c;
         3'h3: duty_of = 14'h20b7;
         3'h4: duty_of = 14'h222e;
         3'h5: duty_of = 14'h249f;
         3'h6: duty_of = 14'h2616;
         default: duty_of = 14'h26ac;
      endcase
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clk);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_wr = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(negedge clk);
      cfg_addr = a;
      cfg_rd = 1'b1;
      @(negedge clk);
      cfg_rd = 1'b0;
      chk("cfg_rvalid", {31'h0, cfg_rvalid}, 32'h1);
      chk("cfg_rdata", cfg_rdata, exp);
      @(negedge clk);
      chk("cfg_rvalid low", {31'h0, cfg_rvalid}, 32'h0);
   endtask

   // One lookup; valid stands only in the cycle after the second edge, while the duty holds after it
   task automatic look(input logic [2:0] s, input logic tp, input logic [13:0] d,
                       input logic [3:0] adv);
      @(negedge clk);
      step_sel = s;
      two_phase_sel = tp;
      step_req = 1'b1;
      @(negedge clk);
      step_req = 1'b0;
      @(negedge clk);
      chk("step_duty_valid", {31'h0, step_duty_valid}, 32'h1);
      chk("step_duty", {18'h0, step_duty}, {18'h0, d});
      chk("advance_deg", {28'h0, advance_deg}, {28'h0, adv});
      @(negedge clk);
      chk("step_duty_valid low", {31'h0, step_duty_valid}, 32'h0);
      chk("step_duty held", {18'h0, step_duty}, {18'h0, d});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      rd(8'h98, 32'h0000_0000);
      rd(8'h96, 32'h0000_0000);
      look(3'h4, 1'b0, 14'h0000, 4'h0);
      $display("test reset done");
   endtask

   task automatic test_three_phase();
      logic [31:0] w;
      logic [2:0] c;
      for (int p = 0; p < 4; p++) begin
         w = {1'b1, 31'h0000_0000};
         for (int i = 0; i < 8; i++) begin
            c = p[0] ? 3'(i + 5) : 3'(i);
            w[30 - 3 * i -: 3] = c;
         end
         w[6:5] = 2'(p);
         w[4:0] = 5'h15;
         wr(8'h98, w);
         rd(8'h98, w);
         for (int i = 0; i < 8; i++) begin
            c = p[0] ? 3'(i + 5) : 3'(i);
            look(3'(i), 1'b0, duty_of(c), 4'(p * 5));
         end
      end
      $display("test three phase done");
   endtask

   task automatic test_two_phase();
      two_word = {1'b1, 31'h0000_0000};
      for (int i = 0; i < 8; i++) begin
         two_word[30 - 3 * i -: 3] = 3'(3 * i + 2);
      end
      two_word[6:0] = 7'h5a;
      wr(8'h96, two_word);
      rd(8'h96, two_word);
      for (int i = 0; i < 8; i++) begin
         look(3'(i), 1'b1, duty_of(3'(3 * i + 2)), 4'h0);
      end
      $display("test two phase done");
   endtask

   task automatic test_unmapped();
      wr(8'h97, 32'hffff_ffff);
      rd(8'h97, 32'h0000_0000);
      rd(8'h96, two_word);
      $display("test unmapped done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      test_reset();
      test_three_phase();
      test_two_phase();
      test_unmapped();
      tally_and_finish();
   end

   // Whole run is a few hundred cycles; this cuts a hang well past that
   initial begin
      #(25 * 4000);
      mismatches++;
      tally_and_finish();
   end
endmodule

// >>> src/duty_profile_pkg.sv
// Constants for the 150-degree duty profile register bank.
// Assumes a single 40 MHz clock domain and a byte-addressed config port.
package duty_profile_pkg;

   // Register addresses on the configuration port
   localparam logic [7:0] TWO_PH_ADDR = 8'h96;
   localparam logic [7:0] THREE_PH_ADDR = 8'h98;
   localparam logic [31:0] PROFILE_RESET = 32'h0000_0000;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // Step duty fields: step 0 sits at 30..28, each next step 3 bits lower
   localparam int STEP_FIELD_W = 3;
   localparam int STEP0_LSB = 28;
   localparam logic [2:0] LAST_STEP = 3'h7;
   localparam logic [2:0] MIDDLE_STEP = 3'h4;
   localparam logic [2:0] FIRST_STEP = 3'h0;

   // Angle advance field and its scale
   localparam int ADV_LSB = 5;
   localparam int ADV_MSB = 6;
   localparam int RSVD_TWO_MSB = 6;
   localparam logic [3:0] ADV_STEP_DEG = 4'h5;

   // Duty in hundredths of a percent, indexed by step code
   localparam int DUTY_W = 14;
   localparam logic [7:0][DUTY_W-1:0] DUTY_BP_TABLE = {
      14'h26ac, 14'h2616, 14'h249f, 14'h222e,
      14'h20b7, 14'h1d4c, 14'h1388, 14'h0000
   };
   localparam logic [DUTY_W-1:0] DUTY_ZERO = 14'h0000;

   // Codes and duties named for checks
   localparam logic [2:0] CODE_HALF = 3'h1;
   localparam logic [2:0] CODE_75 = 3'h2;
   localparam logic [2:0] CODE_8375 = 3'h3;
   localparam logic [2:0] CODE_99 = 3'h7;
   localparam logic [DUTY_W-1:0] DUTY_HALF = 14'h1388;
   localparam logic [DUTY_W-1:0] DUTY_75 = 14'h1d4c;
   localparam logic [DUTY_W-1:0] DUTY_8375 = 14'h20b7;
   localparam logic [DUTY_W-1:0] DUTY_99 = 14'h26ac;

endpackage

// >>> src/modulation_duty_profile_regs.sv
// Duty profile register bank for 150-degree commutation, with step duty lookup.
// Assumes the host config port and the commutation logic share clk.
`timescale 1ns/1ps

module modulation_duty_profile_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host configuration port
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_wr,
   input wire logic [31:0] cfg_wdata,
   input wire logic cfg_rd,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   // Commutation step lookup
   input wire logic step_req,
   input wire logic [2:0] step_sel,
   input wire logic two_phase_sel,
   output logic [duty_profile_pkg::DUTY_W-1:0] step_duty,
   output logic step_duty_valid,
   output logic [3:0] advance_deg
);

   typedef struct packed {
      logic [31:0] three_phase_duty_profile;
      logic [31:0] two_phase_duty_profile;
      logic [31:0] rdata;
      logic rvalid;
      logic dec_pending;
      logic duty_valid;
      logic [duty_profile_pkg::DUTY_W-1:0] duty;
      logic [3:0] advance;
      logic [3:0] advance_shown;
   } regs_state_s;

   regs_state_s st;
   regs_state_s next_st;
   step_duty_if dif ();

   // Field extraction: step codes shared by both registers and both lookups, advance code read from the three-phase register only
   function automatic logic [2:0] step_code(input logic [31:0] r, input logic [2:0] idx);
      logic [31:0] shifted;
      shifted = r >> (duty_profile_pkg::STEP0_LSB - duty_profile_pkg::STEP_FIELD_W * int'(idx));
      return shifted[2:0];
   endfunction

   function automatic logic [1:0] adv_code(input logic [31:0] r);
      return r[duty_profile_pkg::ADV_MSB:duty_profile_pkg::ADV_LSB];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Lookup request to the decoder, taken from the register as it stands now
   always_comb begin
      dif.req = step_req;
      if (two_phase_sel) begin
         dif.code = step_code(st.two_phase_duty_profile, step_sel);
      end else begin
         dif.code = step_code(st.three_phase_duty_profile, step_sel);
      end
   end

   step_duty_decoder u_decoder (
      .clk(clk),
      .rst_n(rst_n),
      .dif(dif)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st = st;
      next_st.rvalid = 1'b0;
      next_st.dec_pending = step_req;
      next_st.duty_valid = st.dec_pending;
      // Writes: every bit is stored, parity and reserved bits included
      if (cfg_wr) begin
         case (cfg_addr)
            duty_profile_pkg::THREE_PH_ADDR: begin
               next_st.three_phase_duty_profile = cfg_wdata;
            end
            duty_profile_pkg::TWO_PH_ADDR: begin
               next_st.two_phase_duty_profile = cfg_wdata;
            end
            default: begin
            end
         endcase
      end
      // Reads return the value before a same-cycle write
      if (cfg_rd) begin
         next_st.rvalid = 1'b1;
         case (cfg_addr)
            duty_profile_pkg::THREE_PH_ADDR: begin
               next_st.rdata = st.three_phase_duty_profile;
            end
            duty_profile_pkg::TWO_PH_ADDR: begin
               next_st.rdata = st.two_phase_duty_profile;
            end
            default: begin
               next_st.rdata = duty_profile_pkg::READ_ZERO;
            end
         endcase
      end
      // Advance follows the three-phase register; the two-phase one has none
      // advance in 5 degree steps
      if (step_req) begin
         if (two_phase_sel) begin
            next_st.advance = 4'h0;
         end else begin
            next_st.advance = 4'(adv_code(st.three_phase_duty_profile))
               * duty_profile_pkg::ADV_STEP_DEG;
         end
      end
      if (st.dec_pending) begin
         next_st.duty = dif.duty;
      end
      // Advance shown two stages behind the request so it lines up with the duty
      next_st.advance_shown = st.advance;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign cfg_rdata = st.rdata;
   assign cfg_rvalid = st.rvalid;
   assign step_duty = st.duty;
   assign step_duty_valid = st.duty_valid;
   assign advance_deg = st.advance_shown;

   ////////////////////////////////////////////////////////////////////////////
   AST_RESET_CLEARS: assert property (@(posedge clk)
      !rst_n |=> st.three_phase_duty_profile == duty_profile_pkg::PROFILE_RESET
         && st.two_phase_duty_profile == duty_profile_pkg::PROFILE_RESET)
      else $error("profile registers not cleared by reset");

   AST_THREE_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_wr && cfg_addr == duty_profile_pkg::THREE_PH_ADDR
      |=> st.three_phase_duty_profile == $past(cfg_wdata))
      else $error("three-phase profile write not stored");

   AST_ADVANCE: assert property (@(posedge clk) disable iff (!rst_n)
      step_req && !two_phase_sel
      |-> ##2 advance_deg == 4'($past(adv_code(st.three_phase_duty_profile), 2))
         * duty_profile_pkg::ADV_STEP_DEG)
      else $error("angle advance not five degrees per code");

   AST_TWO_LAST_STEP: assert property (@(posedge clk) disable iff (!rst_n)
      step_req && two_phase_sel && step_sel == duty_profile_pkg::LAST_STEP
         && step_code(st.two_phase_duty_profile, step_sel) == duty_profile_pkg::CODE_99
      |-> ##2 step_duty_valid && step_duty == duty_profile_pkg::DUTY_99)
      else $error("two-phase step 7 duty wrong");

   AST_TWO_RESERVED: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_wr && cfg_addr == duty_profile_pkg::TWO_PH_ADDR
      |=> st.two_phase_duty_profile[duty_profile_pkg::RSVD_TWO_MSB:0]
         == $past(cfg_wdata[duty_profile_pkg::RSVD_TWO_MSB:0]))
      else $error("two-phase reserved bits not stored");

   AST_TWO_READ: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_rd && cfg_addr == duty_profile_pkg::TWO_PH_ADDR
      |=> cfg_rvalid && cfg_rdata == $past(st.two_phase_duty_profile))
      else $error("two-phase profile read wrong");

   AST_TWO_FIRST_STEP: assert property (@(posedge clk) disable iff (!rst_n)
      step_req && two_phase_sel && step_sel == duty_profile_pkg::FIRST_STEP
         && step_code(st.two_phase_duty_profile, step_sel) == duty_profile_pkg::CODE_75
      |-> ##2 step_duty_valid && step_duty == duty_profile_pkg::DUTY_75)
      else $error("two-phase step 0 duty wrong");

   AST_THREE_MIDDLE: assert property (@(posedge clk) disable iff (!rst_n)
      step_req && !two_phase_sel && step_sel == duty_profile_pkg::MIDDLE_STEP
         && step_code(st.three_phase_duty_profile, step_sel) == duty_profile_pkg::CODE_HALF
      |-> ##2 step_duty_valid && step_duty == duty_profile_pkg::DUTY_HALF)
      else $error("three-phase step 4 duty wrong");

   AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_rd && cfg_addr != duty_profile_pkg::THREE_PH_ADDR
         && cfg_addr != duty_profile_pkg::TWO_PH_ADDR
      |=> cfg_rvalid && cfg_rdata == duty_profile_pkg::READ_ZERO)
      else $error("unmapped read not zero");

   AST_RVALID_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
      !cfg_rd
      |=> !cfg_rvalid)
      else $error("read answer without a read strobe");

   AST_DUTY_VALID_ON: assert property (@(posedge clk) disable iff (!rst_n)
      step_req
      |-> ##2 step_duty_valid)
      else $error("lookup answer missing two edges after request");

   AST_DUTY_VALID_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      !step_req
      |-> ##2 !step_duty_valid)
      else $error("lookup answer without a request");

   AST_TWO_NO_ADVANCE: assert property (@(posedge clk) disable iff (!rst_n)
      step_req && two_phase_sel
      |-> ##2 advance_deg == 4'h0)
      else $error("two-phase lookup showed an angle advance");

   AST_THREE_LAST_STEP: assert property (@(posedge clk) disable iff (!rst_n)
      step_req && !two_phase_sel && step_sel == duty_profile_pkg::LAST_STEP
         && step_code(st.three_phase_duty_profile, step_sel) == duty_profile_pkg::CODE_99
      |-> ##2 step_duty_valid && step_duty == duty_profile_pkg::DUTY_99)
      else $error("three-phase step 7 duty wrong");

endmodule

// >>> src/step_duty_decoder.sv
// Maps a 3-bit step duty code to a duty in hundredths of a percent.
// Assumes the requester holds code with req; duty is registered, one edge later.
`timescale 1ns/1ps
module step_duty_decoder (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Code in, duty out
   step_duty_if.decoder dif
);

   typedef struct packed {
      logic [duty_profile_pkg::DUTY_W-1:0] duty;
   } dec_state_s;

   dec_state_s st;
   dec_state_s next_st;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st = st;
      if (dif.req) begin
         next_st.duty = duty_profile_pkg::DUTY_BP_TABLE[dif.code];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dif.duty = st.duty;

   ////////////////////////////////////////////////////////////////////////////
   AST_CODE_TO_DUTY: assert property (@(posedge clk) disable iff (!rst_n)
      dif.req && dif.code == duty_profile_pkg::CODE_8375
      |=> dif.duty == duty_profile_pkg::DUTY_8375)
      else $error("code 3 did not decode to 83.75 percent");

endmodule

// >>> src/step_duty_if.sv
// Carries one step duty code to the decoder and its duty back.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface step_duty_if;
   logic req;
   logic [2:0] code;
   logic [duty_profile_pkg::DUTY_W-1:0] duty;

   modport requester (output req, output code, input duty);
   modport decoder (input req, input code, output duty);
endinterface
